// [fsg_pkg.sv]
// Package of constants, types and register map for the flash security gate.
`default_nettype none
package fsg_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [11:0] ADDR_CMD    = 12'h000;
    localparam logic [11:0] ADDR_ARG    = 12'h004;
    localparam logic [11:0] ADDR_STAT   = 12'h008;
    localparam logic [11:0] ADDR_SEC    = 12'h00C;
    localparam logic [11:0] ADDR_SECWR  = 12'h010;
    localparam logic [11:0] ADDR_IRQST  = 12'h014;
    localparam logic [11:0] ADDR_IRQMSK = 12'h018;
    localparam logic [11:0] ADDR_RDATA  = 12'h01C;

    // Security setting bit positions.
    localparam int SEC_BLK  = 0;
    localparam int SEC_CHIP = 1;
    localparam int SEC_PROG = 2;
    localparam int SEC_READ = 3;
    localparam int SEC_BOOT = 4;
    localparam int SEC_W    = 5;

    // Shipped default: block erase, chip erase and program prohibited.
    localparam logic [4:0] SEC_DEFAULT = 5'h07;
    // Settings a chip erase returns to the open state.
    localparam logic [4:0] SEC_CHIP_CLR = 5'h0D;

    // Command word fields.
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_SRC_BIT = 4;
    localparam int CMD_GO_BIT  = 31;
    // Source bit of a security write and block field of the argument.
    localparam int SECWR_SRC_BIT = 8;
    localparam int ARG_BLK_LSB   = 24;

    // Status bit positions.
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR  = 2;
    localparam int ST_BLNK = 3;
    localparam int ST_MISM = 4;
    localparam int ST_SECW = 5;

    // Interrupt event bits.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REJ  = 1;
    localparam int IRQ_W    = 2;

    // Boot area occupies the blocks with index below this value.
    localparam logic [7:0] BOOT_BLOCKS = 8'h04;
    localparam logic [7:0] NUM_BLOCKS  = 8'h40;

    // Time one flash operation takes, and its cycle count at 25 MHz.
    localparam int CLK_MHZ    = 25;
    localparam int OP_TIME_NS = 400;
    localparam int OP_CYCLES  = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] OP_CNT = 8'(OP_CYCLES);

    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_BLKER = 3'h1,
        OP_CHIPER = 3'h2,
        OP_WRITE = 3'h3,
        OP_VERIFY = 3'h4,
        OP_READ  = 3'h5,
        OP_BLANK = 3'h6
    } fsg_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN  = 2'h1
    } fsg_state_e;

    // Source of a command: external programmer or self-programming code.
    localparam logic SRC_EXT  = 1'b0;
    localparam logic SRC_SELF = 1'b1;

endpackage : fsg_pkg
`default_nettype wire

// [fsg_check.sv]
// Combinational security check of one flash command.
`timescale 1ns/1ps
`default_nettype none
module fsg_check (
    input  wire logic [2:0] op,
    input  wire logic       src,
    input  wire logic [7:0] blk,
    input  wire logic [4:0] sec,
    output logic            reject
);
    logic boot_hit;
    logic chip_op;

    always_comb begin
        chip_op  = (op == fsg_pkg::OP_CHIPER);
        boot_hit = chip_op || (blk < fsg_pkg::BOOT_BLOCKS);
        reject   = 1'b0;
        // Every setting is tested on its own so any mix may be active.
        unique case (op)
            fsg_pkg::OP_BLKER: begin
                reject = sec[fsg_pkg::SEC_BLK] || sec[fsg_pkg::SEC_CHIP]
                    || sec[fsg_pkg::SEC_PROG];
            end
            fsg_pkg::OP_CHIPER: begin
                reject = sec[fsg_pkg::SEC_CHIP]
                    || (src == fsg_pkg::SRC_SELF);
            end
            fsg_pkg::OP_WRITE: begin
                reject = sec[fsg_pkg::SEC_PROG];
            end
            fsg_pkg::OP_READ: begin
                reject = sec[fsg_pkg::SEC_READ];
            end
            fsg_pkg::OP_VERIFY: begin
                reject = (src == fsg_pkg::SRC_SELF);
            end
            fsg_pkg::OP_BLANK: begin
                reject = 1'b0;
            end
            default: begin
                reject = 1'b1;
            end
        endcase
        if (sec[fsg_pkg::SEC_BOOT] && boot_hit
            && (op == fsg_pkg::OP_WRITE || op == fsg_pkg::OP_BLKER
                || chip_op)) begin
            reject = 1'b1;
        end
    end
endmodule : fsg_check
`default_nettype wire

// [fsg_flash.sv]
// Small flash array model with block erase, chip erase, write and read.
`timescale 1ns/1ps
`default_nettype none
module fsg_flash (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        blk_erase,
    input  wire logic        chip_erase,
    input  wire logic        wr,
    input  wire logic [7:0]  blk,
    input  wire logic [31:0] wdata,
    output logic [31:0]      rdata,
    output logic             all_blank
);
    // One word per block keeps the array small while still erasing by block.
    logic [31:0] mem [64];
    logic [63:0] blank_r;

    always_ff @(posedge clk) begin
        if (chip_erase) begin
            for (int i = 0; i < 64; i++) begin
                mem[i] <= 32'hFFFFFFFF;
            end
        end else if (blk_erase) begin
            mem[blk[5:0]] <= 32'hFFFFFFFF;
        end else if (wr) begin
            mem[blk[5:0]] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blank_r <= 64'hFFFFFFFFFFFFFFFF;
        end else if (chip_erase) begin
            blank_r <= 64'hFFFFFFFFFFFFFFFF;
        end else if (blk_erase) begin
            blank_r[blk[5:0]] <= 1'b1;
        end else if (wr) begin
            blank_r[blk[5:0]] <= (wdata == 32'hFFFFFFFF);
        end
    end

    assign rdata     = mem[blk[5:0]];
    assign all_blank = &blank_r;
endmodule : fsg_flash
`default_nettype wire

// [fsg_gate.sv]
// Flash security command gate with APB registers and interrupt.
`timescale 1ns/1ps
`default_nettype none
module fsg_gate (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    typedef struct packed {
        fsg_pkg::fsg_state_e      state;
        logic [2:0]               op;
        logic                     src;
        logic [7:0]               blk;
        logic [31:0]              arg;
        logic [4:0]               sec;
        logic [4:0]               stat;
        logic [7:0]               cnt;
        logic [fsg_pkg::IRQ_W-1:0] irq_st;
        logic [fsg_pkg::IRQ_W-1:0] irq_msk;
        logic [31:0]              rdata;
        logic                     secw_err;
    } fsg_state_s;

    fsg_state_s st_r;
    fsg_state_s st_nxt;

    logic        wr_acc;
    logic        rd_acc;
    logic        reject;
    logic [31:0] fl_rdata;
    logic        fl_blank;
    logic        do_blk;
    logic        do_chip;
    logic        do_wr;
    logic [2:0]  new_op;
    logic        new_src;
    logic [7:0]  new_blk;
    logic        finish;
    logic [fsg_pkg::IRQ_W-1:0] irq_ev;

    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign new_op  = pwdata[fsg_pkg::CMD_OP_LSB +: 3];
    assign new_src = pwdata[fsg_pkg::CMD_SRC_BIT];
    assign new_blk = st_r.arg[fsg_pkg::ARG_BLK_LSB +: 8];
    assign finish  = (st_r.state == fsg_pkg::ST_RUN)
        && (st_r.cnt == 8'h00);

    fsg_check u_check (
        .op     (st_r.op),
        .src    (st_r.src),
        .blk    (st_r.blk),
        .sec    (st_r.sec),
        .reject (reject)
    );

    // Flash is only touched on the final cycle of an accepted command.
    assign do_blk  = finish && !reject && (st_r.op == fsg_pkg::OP_BLKER);
    assign do_chip = finish && !reject && (st_r.op == fsg_pkg::OP_CHIPER);
    assign do_wr   = finish && !reject && (st_r.op == fsg_pkg::OP_WRITE);

    fsg_flash u_flash (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .blk_erase  (do_blk),
        .chip_erase (do_chip),
        .wr         (do_wr),
        .blk        (st_r.blk),
        .wdata      (st_r.arg),
        .rdata      (fl_rdata),
        .all_blank  (fl_blank)
    );

    function automatic logic [4:0] sec_update(
        input logic [4:0] cur,
        input logic [4:0] req,
        input logic       self_src
    );
        logic [4:0] res;
        res = req;
        if (self_src) begin
            res = cur & req;
        end
        // Boot protection sticks and chip protection cannot be dropped.
        res[fsg_pkg::SEC_BOOT] = res[fsg_pkg::SEC_BOOT]
            | cur[fsg_pkg::SEC_BOOT];
        res[fsg_pkg::SEC_CHIP] = res[fsg_pkg::SEC_CHIP]
            | cur[fsg_pkg::SEC_CHIP];
        return res;
    endfunction : sec_update

    always_comb begin
        st_nxt = st_r;
        irq_ev = '0;
        unique case (st_r.state)
            fsg_pkg::ST_IDLE: begin
                if (wr_acc && paddr == fsg_pkg::ADDR_CMD
                    && pwdata[fsg_pkg::CMD_GO_BIT]) begin
                    st_nxt.state = fsg_pkg::ST_RUN;
                    st_nxt.op    = new_op;
                    st_nxt.src   = new_src;
                    st_nxt.blk   = new_blk;
                    st_nxt.cnt   = fsg_pkg::OP_CNT;
                    st_nxt.stat  = 5'h01;
                end
            end
            fsg_pkg::ST_RUN: begin
                if (st_r.cnt != 8'h00) begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end else begin
                    st_nxt.state = fsg_pkg::ST_IDLE;
                    st_nxt.stat[fsg_pkg::ST_BUSY] = 1'b0;
                    st_nxt.stat[fsg_pkg::ST_DONE] = 1'b1;
                    if (reject) begin
                        st_nxt.stat[fsg_pkg::ST_ERR] = 1'b1;
                        irq_ev[fsg_pkg::IRQ_REJ] = 1'b1;
                    end else begin
                        unique case (st_r.op)
                            fsg_pkg::OP_CHIPER: begin
                                st_nxt.sec = st_r.sec
                                    & ~fsg_pkg::SEC_CHIP_CLR;
                            end
                            fsg_pkg::OP_READ: begin
                                st_nxt.rdata = fl_rdata;
                            end
                            fsg_pkg::OP_VERIFY: begin
                                st_nxt.stat[fsg_pkg::ST_MISM] =
                                    (fl_rdata != st_r.arg);
                            end
                            fsg_pkg::OP_BLANK: begin
                                st_nxt.stat[fsg_pkg::ST_BLNK] =
                                    fl_blank;
                            end
                            default: begin
                            end
                        endcase
                        irq_ev[fsg_pkg::IRQ_DONE] = 1'b1;
                    end
                    if (st_r.op == fsg_pkg::OP_WRITE && !reject) begin
                        // Write then verify: check needs the stored value.
                        st_nxt.state = fsg_pkg::ST_RUN;
                        st_nxt.op    = fsg_pkg::OP_VERIFY;
                        st_nxt.cnt   = fsg_pkg::OP_CNT;
                        st_nxt.stat  = 5'h01;
                        // The check after a write is internal, not a user
                        // verify, so it runs as the external side.
                        st_nxt.src   = fsg_pkg::SRC_EXT;
                        irq_ev[fsg_pkg::IRQ_DONE] = 1'b0;
                    end
                end
            end
            default: begin
                st_nxt.state = fsg_pkg::ST_IDLE;
            end
        endcase
        if (wr_acc) begin
            unique case (paddr)
                fsg_pkg::ADDR_ARG: begin
                    if (st_r.state == fsg_pkg::ST_IDLE) begin
                        st_nxt.arg = pwdata;
                    end
                end
                fsg_pkg::ADDR_SECWR: begin
                    st_nxt.sec = sec_update(st_r.sec,
                        pwdata[fsg_pkg::SEC_W-1:0],
                        pwdata[fsg_pkg::SECWR_SRC_BIT]);
                    st_nxt.secw_err = pwdata[fsg_pkg::SECWR_SRC_BIT]
                        && ((pwdata[fsg_pkg::SEC_W-1:0] & ~st_r.sec)
                            != 5'h00);
                end
                fsg_pkg::ADDR_IRQMSK: begin
                    st_nxt.irq_msk = pwdata[fsg_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Read clears status; a same-cycle event still wins.
        // Events are kept apart so a clearing read never swallows one.
        st_nxt.irq_st = st_r.irq_st | irq_ev;
        if (rd_acc && paddr == fsg_pkg::ADDR_IRQST) begin
            st_nxt.irq_st = irq_ev;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r         <= '0;
            st_r.state   <= fsg_pkg::ST_IDLE;
            st_r.sec     <= fsg_pkg::SEC_DEFAULT;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        prdata  = 32'h00000000;
        pslverr = 1'b0;
        unique case (paddr)
            fsg_pkg::ADDR_CMD: begin
                prdata = {29'h0, st_r.op};
            end
            fsg_pkg::ADDR_ARG: begin
                prdata = st_r.arg;
            end
            fsg_pkg::ADDR_STAT: begin
                prdata = {26'h0, st_r.secw_err, st_r.stat};
            end
            fsg_pkg::ADDR_SEC, fsg_pkg::ADDR_SECWR: begin
                prdata = {27'h0, st_r.sec};
            end
            fsg_pkg::ADDR_IRQST: begin
                prdata = {30'h0, st_r.irq_st};
            end
            fsg_pkg::ADDR_IRQMSK: begin
                prdata = {30'h0, st_r.irq_msk};
            end
            fsg_pkg::ADDR_RDATA: begin
                prdata = st_r.rdata;
            end
            default: begin
                pslverr = psel && penable;
            end
        endcase
    end

    assign irq = |(st_r.irq_st & st_r.irq_msk);

    // Every property below is cut off while reset is held.
    a_boot_sticky: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(st_r.sec[fsg_pkg::SEC_BOOT]) |-> st_r.sec[fsg_pkg::SEC_BOOT])
        else $error("boot prohibition dropped");
    a_chip_sticky: assert property (
        @(posedge clk) disable iff (sys_rst)
        $past(st_r.sec[fsg_pkg::SEC_CHIP]) |-> st_r.sec[fsg_pkg::SEC_CHIP])
        else $error("chip prohibition dropped");
    a_reject_noerase: assert property (
        @(posedge clk) disable iff (sys_rst)
        (finish && reject) |-> !(do_blk || do_chip || do_wr))
        else $error("rejected command touched flash");
    a_reject_err: assert property (
        @(posedge clk) disable iff (sys_rst)
        (finish && reject) |=> st_r.stat[fsg_pkg::ST_ERR])
        else $error("reject without error status");
    a_self_chip: assert property (
        @(posedge clk) disable iff (sys_rst)
        (finish && st_r.op == fsg_pkg::OP_CHIPER && st_r.src) |-> !do_chip)
        else $error("self chip erase ran");
    a_read_block: assert property (
        @(posedge clk) disable iff (sys_rst)
        (finish && st_r.op == fsg_pkg::OP_READ
            && st_r.sec[fsg_pkg::SEC_READ]) |-> reject)
        else $error("read not blocked");
    a_prog_block: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_r.sec[fsg_pkg::SEC_PROG] && st_r.op == fsg_pkg::OP_WRITE)
            |-> !do_wr)
        else $error("write not blocked");
    a_blk_block: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_r.sec[fsg_pkg::SEC_BLK]) |-> !do_blk)
        else $error("block erase not blocked");
    a_chip_clears: assert property (
        @(posedge clk) disable iff (sys_rst)
        do_chip |=> !st_r.sec[fsg_pkg::SEC_READ]
            && !st_r.sec[fsg_pkg::SEC_PROG] && !st_r.sec[fsg_pkg::SEC_BLK])
        else $error("chip erase kept settings");
    a_chip_lock: assert property (
        @(posedge clk) disable iff (sys_rst)
        st_r.sec[fsg_pkg::SEC_CHIP] |-> !(do_blk || do_chip))
        else $error("erase ran under chip prohibition");
    a_boot_area: assert property (
        @(posedge clk) disable iff (sys_rst)
        st_r.sec[fsg_pkg::SEC_BOOT] |-> !do_chip
            && !((do_blk || do_wr) && st_r.blk < fsg_pkg::BOOT_BLOCKS))
        else $error("boot area rewritten");

    a_self_sec: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_acc && paddr == fsg_pkg::ADDR_SECWR
            && pwdata[fsg_pkg::SECWR_SRC_BIT])
        |=> (st_r.sec & ~$past(st_r.sec)) == 5'h00)
        else $error("self write raised a setting");
    a_self_verify: assert property (
        @(posedge clk) disable iff (sys_rst)
        (finish && st_r.op == fsg_pkg::OP_VERIFY
            && st_r.src == fsg_pkg::SRC_SELF) |-> reject)
        else $error("self verify accepted");
    a_blank_report: assert property (
        @(posedge clk) disable iff (sys_rst)
        (finish && !reject && st_r.op == fsg_pkg::OP_BLANK)
        |=> st_r.stat[fsg_pkg::ST_BLNK] == $past(fl_blank))
        else $error("blank status wrong");

    // A set event must survive a status read that lands in the same cycle.
    a_done_event: assert property (
        @(posedge clk) disable iff (sys_rst)
        (finish && !reject && st_r.op != fsg_pkg::OP_WRITE)
        |=> st_r.irq_st[fsg_pkg::IRQ_DONE])
        else $error("done event lost");
    a_irq_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_acc && paddr == fsg_pkg::ADDR_IRQST && !finish)
        |=> st_r.irq_st == '0)
        else $error("status read did not clear");
    a_arg_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (st_r.state == fsg_pkg::ST_RUN) |=> st_r.arg == $past(st_r.arg))
        else $error("argument changed while busy");

    // A write and its check are two steps, so both ends are named.
    sequence s_write_end;
        finish && !reject && st_r.op == fsg_pkg::OP_WRITE;
    endsequence
    sequence s_check_start;
        st_r.state == fsg_pkg::ST_RUN && st_r.op == fsg_pkg::OP_VERIFY
            && st_r.cnt == fsg_pkg::OP_CNT;
    endsequence
    a_write_verify: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_write_end |=> s_check_start)
        else $error("write not followed by check");
endmodule : fsg_gate
`default_nettype wire

// [fsg_prog_model.sv]
// Model of the external programmer that drives the gate's APB port.
`timescale 1ns/1ps
`default_nettype none
module fsg_prog_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // The programmer speaks over one link only, so requests arrive in order.
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    // One transfer; the request holds until pready is seen high.
    task automatic xfer(
        input  logic        w,
        input  logic [11:0] a,
        input  logic [31:0] d,
        output logic [31:0] q,
        output logic        e
    );
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Stale data would hide a slave that samples outside the access.
        pwdata  <= ~d;
    endtask : xfer
endmodule : fsg_prog_model
`default_nettype wire

// [fsg_tb.sv]
// Self-checking testbench of the flash security command gate.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] st;
    logic [31:0] q;
    logic        e;
    int          n_mismatch;
    int          cmp_count;

    fsg_gate dut_u (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq)
    );

    fsg_prog_model prog_u (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        prog_u.xfer(1'b1, a, d, r, x);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic x;
        prog_u.xfer(1'b0, a, 32'h00000000, r, x);
    endtask : rd

    // Runs one command; an expected error of z skips the error compare.
    task automatic run(input logic [2:0] op, input logic s,
                       input logic [31:0] arg, input logic xerr);
        int n;
        n = 0;
        wr(fsg_pkg::ADDR_ARG, arg);
        wr(fsg_pkg::ADDR_CMD, {1'b1, 26'h0, s, 1'b0, op});
        do begin
            rd(fsg_pkg::ADDR_STAT, st);
            n++;
        end while (st[fsg_pkg::ST_BUSY] !== 1'b0 && n < 100);
        chk("cmd finished", 32'h0, {31'h0, st[fsg_pkg::ST_BUSY]});
        if (xerr !== 1'bz)
            chk("cmd error", {31'h0, xerr}, {31'h0, st[fsg_pkg::ST_ERR]});
    endtask : run

    task automatic secwr(input logic s, input logic [4:0] v,
                         input logic [4:0] x);
        wr(fsg_pkg::ADDR_SECWR, {23'h0, s, 3'h0, v});
        rd(fsg_pkg::ADDR_SEC, q);
        chk("security", {27'h0, x}, {27'h0, q[4:0]});
    endtask : secwr

    task automatic bit_chk(input string nm, input int b, input logic x);
        chk(nm, {31'h0, x}, {31'h0, st[b]});
    endtask : bit_chk

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    initial begin
        n_mismatch = 0;
        cmp_count  = 0;
        sys_rst    = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(fsg_pkg::ADDR_SEC, q);
        chk("sec reset", 32'h00000007, {27'h0, q[4:0]});
        rd(fsg_pkg::ADDR_IRQST, q);
        chk("irq status reset", 32'h00000000, q);
        run(fsg_pkg::OP_BLKER, 1'b0, 32'h08000000, 1'b1);
        run(fsg_pkg::OP_WRITE, 1'b0, 32'h08ABCDEF, 1'b1);
        run(fsg_pkg::OP_CHIPER, 1'b0, 32'h00000000, 1'b1);
        @(negedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(fsg_pkg::ADDR_IRQMSK, 32'h00000003);
        @(negedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd(fsg_pkg::ADDR_IRQST, q);
        chk("reject event", 32'h2, q);
        @(negedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        secwr(1'b0, 5'h00, 5'h02);
        secwr(1'b1, 5'h0A, 5'h02);
        rd(fsg_pkg::ADDR_STAT, st);
        bit_chk("sec refused", fsg_pkg::ST_SECW, 1'b1);
        secwr(1'b0, 5'h0A, 5'h0A);
        run(fsg_pkg::OP_READ, 1'b0, 32'h08000000, 1'b1);
        secwr(1'b1, 5'h02, 5'h02);
        run(fsg_pkg::OP_WRITE, 1'b0, 32'h08ABCDEF, 1'b0);
        bit_chk("write verify", fsg_pkg::ST_MISM, 1'b0);
        run(fsg_pkg::OP_VERIFY, 1'b0, 32'h08ABCDEF, 1'b0);
        bit_chk("verify match", fsg_pkg::ST_MISM, 1'b0);
        run(fsg_pkg::OP_READ, 1'b0, 32'h08000000, 1'b0);
        rd(fsg_pkg::ADDR_RDATA, q);
        chk("read data", 32'h08ABCDEF, q);
        run(fsg_pkg::OP_VERIFY, 1'b1, 32'h08ABCDEF, 1'b1);
        run(fsg_pkg::OP_CHIPER, 1'b1, 32'h00000000, 1'b1);
        run(fsg_pkg::OP_WRITE, 1'b1, 32'h09123456, 1'b0);
        run(fsg_pkg::OP_BLKER, 1'b1, 32'h08000000, 1'b1);
        run(fsg_pkg::OP_VERIFY, 1'b0, 32'h08ABCDEF, 1'b0);
        bit_chk("block kept", fsg_pkg::ST_MISM, 1'b0);
        run(fsg_pkg::OP_VERIFY, 1'b0, 32'h09123456, 1'b0);
        bit_chk("kept block", fsg_pkg::ST_MISM, 1'b0);
        run(fsg_pkg::OP_BLANK, 1'b0, 32'h00000000, 1'b0);
        bit_chk("not blank", fsg_pkg::ST_BLNK, 1'b0);
        run(fsg_pkg::OP_WRITE, 1'b0, 32'h02111111, 1'b0);
        secwr(1'b0, 5'h12, 5'h12);
        run(fsg_pkg::OP_WRITE, 1'b0, 32'h02222222, 1'b1);
        run(fsg_pkg::OP_BLKER, 1'b0, 32'h02000000, 1'b1);
        run(fsg_pkg::OP_VERIFY, 1'b0, 32'h02111111, 1'b0);
        bit_chk("boot kept", fsg_pkg::ST_MISM, 1'b0);
        run(fsg_pkg::OP_WRITE, 1'b0, 32'h05555555, 1'b0);
        secwr(1'b0, 5'h00, 5'h12);
        prog_u.xfer(1'b0, 12'h020, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        test_done();
    end
endmodule : testbench
`default_nettype wire
